// File: inc/reverse_translator_defines.svh
/*
 * Constants of the reverse address translator: table geometry,
 * range layout and field widths.
 * Assumes a 32-bit physical bus address and ranges of 32 Mbytes.
 */
`ifndef REVERSE_TRANSLATOR_DEFINES_SVH
`define REVERSE_TRANSLATOR_DEFINES_SVH

// ----------------------------------------------------------------
// Table geometry
// ----------------------------------------------------------------
`define RT_ENTRIES 8
`define RT_HALF 4'h4
`define RT_FULL 4'h8
`define RT_IDX_W 4

// ----------------------------------------------------------------
// Address layout: 32 Mbyte ranges, low 25 bits are the offset
// ----------------------------------------------------------------
`define RT_ADDR_W 32
`define RT_OFS_W 25
`define RT_BLK_W 7
`define RT_SIZE_W 32

`endif

// File: inc/rt_pkg.sv
/*
 * Types shared by the reverse address translator.
 * Assumes reverse_translator_defines.svh is on the include path.
 */
`include "reverse_translator_defines.svh"
package rt_pkg;
   // Upper physical or logical bits of one 32 Mbyte range
   typedef logic [`RT_BLK_W-1:0] block_t;

   // One translation table entry
   typedef struct packed {
      logic valid;
      logic isSuper;
      block_t physBlock;
      block_t logBlock;
      logic inMap;
      logic fromTt;
      logic [`RT_SIZE_W-1:0] mapSize;
   } entry_s;

   // One candidate range offered by the loader
   typedef struct packed {
      logic isSuper;
      block_t physBlock;
      block_t logBlock;
      logic inMap;
      logic fromTt;
      logic [`RT_SIZE_W-1:0] mapSize;
   } cand_s;

   // One processor bus address or analyzer address
   typedef struct packed {
      logic valid;
      logic isSuper;
      logic [`RT_ADDR_W-1:0] addr;
   } bus_s;

   // Load sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_HALT = 2'b01,
      ST_FILL = 2'b10,
      ST_COMMIT = 2'b11
   } load_state_e;
endpackage

// File: verilog/reverse_translator.sv
/*
 * Reverse address translator: turns physical bus addresses back into
 * logical ones for the trace analyzer, from an eight-entry range table.
 * Assumes a loader that streams candidate ranges after the monitor
 * has halted the target, and bus inputs synchronous to sys_clk.
 */
`include "reverse_translator_defines.svh"

// What this block does
// R1 - Disabled with MMU on: raw physical addresses
// R2 - Enabled: translate from last loaded table
// R3 - Finished load leaves translator enabled
// R4 - Eight entries of 32 Mbytes each
// R5 - One logical address per physical range
// R6 - Among aliases prefer lowest logical address
// R7 - Page table alias beats transparent alias
// R8 - Memory map alias beats unmapped alias
// R9 - Memory map ordering matters only on overflow
// R10 - Map terms sorted size then address
// R11 - Remaining ranges fill in ascending address
// R12 - Leftover ranges raise out of resources
// R13 - Table frozen at load; changes need reload
// R14 - Halt target during load, resume after
// R15 - Analyzer must not trace during load
// R16 - File load ignores live translation setup
// R17 - MMU off: output equals bus address
// R18 - One translation per cycle, never stalls
// R19 - Split root pointers: halves user, supervisor
// R20 - Hit replaces upper bits, keeps offset
// R21 - Miss passes physical address unchanged
module reverse_translator #(
   parameter int NUM_ENTRIES = `RT_ENTRIES
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire rt_pkg::bus_s busIn,
   input wire logic mmuEnabled,
   input wire logic [`RT_ADDR_W-1:0] user_root_pointer,
   input wire logic [`RT_ADDR_W-1:0] supervisor_root_pointer,
   input wire logic ttFcUsed,
   input wire logic enableCmd,
   input wire logic disableCmd,
   input wire logic loadStart,
   input wire logic fileLoad,
   input wire logic fileSplit,
   input wire logic traceActive,
   input wire logic monitorHalted,
   input wire rt_pkg::cand_s cand,
   input wire logic candValid,
   input wire logic loadEnd,
   output logic candReady,
   output logic haltReq,
   output logic translating,
   output logic outOfResources,
   output rt_pkg::bus_s anaOut
);
   import rt_pkg::*;

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   logic [1:0] rstSync_ff; // Two-stage release of the reset
   logic rstN; // Synchronised reset used everywhere else

   // Async assert, clocked release
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rstSync_ff <= 2'h0;
      end else begin
         rstSync_ff <= {rstSync_ff[0], 1'b1};
      end
   end
   assign rstN = rstSync_ff[1];

   // ----------------------------------------------------------------
   // Load sequencer and staging table
   // ----------------------------------------------------------------
   load_state_e state_ff, nxt_state; // Sequencer state
   entry_s [NUM_ENTRIES-1:0] stage_ff, nxt_stage; // Table being built
   entry_s [NUM_ENTRIES-1:0] live_ff, nxt_live; // Table in use
   logic stageSplit_ff, nxt_stageSplit; // Split chosen at load start
   logic liveSplit_ff, nxt_liveSplit; // Split of the table in use
   logic enabled_ff, nxt_enabled; // Translator switched on
   logic oor_ff, nxt_oor; // Out of resources
   logic halt_ff, nxt_halt; // Monitor break request
   logic [`RT_IDX_W-1:0] segLo, segHi, insPos, aliasIdx, below;
   logic aliasHit; // Candidate shares a physical range
   logic candAccept; // Candidate taken this cycle
   entry_s candEntry; // Candidate shaped as an entry

   // Sort key: map terms first by size, then all by address
   function automatic logic [`RT_SIZE_W+`RT_BLK_W:0] sortKey(
      input logic inMap, input logic [`RT_SIZE_W-1:0] size,
      input block_t phys);
      sortKey = {~inMap, inMap ? size : {`RT_SIZE_W{1'b0}}, phys};
   endfunction

   // True when the candidate alias is preferred over the stored one
   function automatic logic betterAlias(input cand_s c, input entry_s e);
      if (c.inMap != e.inMap) begin
         betterAlias = c.inMap; // [R8]
      end else if (c.fromTt != e.fromTt) begin
         betterAlias = !c.fromTt; // [R7]
      end else begin
         betterAlias = c.logBlock < e.logBlock; // [R6]
      end
   endfunction

   assign candReady = (state_ff == ST_FILL); // [R18]
   assign candAccept = candReady && candValid;
   assign candEntry = '{valid: 1'b1, isSuper: cand.isSuper, physBlock: cand.physBlock,
      logBlock: cand.logBlock, inMap: cand.inMap, fromTt: cand.fromTt,
      mapSize: cand.mapSize};

   // Segment of the table that the candidate may occupy
   always_comb begin
      segLo = (stageSplit_ff && cand.isSuper) ? `RT_HALF : 4'h0; // [R19]
      segHi = stageSplit_ff ? segLo + `RT_HALF : `RT_FULL; // [R4]
      aliasHit = 1'b0;
      aliasIdx = 4'h0;
      below = 4'h0;
      for (int i = 0; i < NUM_ENTRIES; i++) begin
         if (4'(i) >= segLo && 4'(i) < segHi && stage_ff[i].valid) begin
            // Same physical range already stored
            if (stage_ff[i].physBlock == cand.physBlock) begin
               aliasHit = 1'b1;
               aliasIdx = 4'(i);
            end
            // Entries that sort ahead of the candidate
            if (sortKey(stage_ff[i].inMap, stage_ff[i].mapSize, stage_ff[i].physBlock)
                  < sortKey(cand.inMap, cand.mapSize, cand.physBlock)) begin
               below = below + 4'h1;
            end
         end
      end
      insPos = segLo + below;
   end

   // Next values of the sequencer and both tables
   always_comb begin
      nxt_state = state_ff;
      nxt_stage = stage_ff;
      nxt_live = live_ff;
      nxt_stageSplit = stageSplit_ff;
      nxt_liveSplit = liveSplit_ff;
      nxt_enabled = enabled_ff;
      nxt_oor = oor_ff;
      // Software switching on or off
      if (enableCmd) begin
         nxt_enabled = 1'b1;
      end else if (disableCmd) begin
         nxt_enabled = 1'b0;
      end
      unique case (state_ff)
         ST_IDLE: begin
            // Start refused while a trace runs
            if (loadStart && !traceActive) begin // [R15]
               nxt_state = ST_HALT;
               nxt_stage = '0;
               nxt_oor = 1'b0;
               // File setup replaces the live root pointers
               nxt_stageSplit = fileLoad ? fileSplit : // [R16]
                  ((user_root_pointer != supervisor_root_pointer) || ttFcUsed); // [R19]
            end
         end
         ST_HALT: begin
            // Wait until the monitor holds the target
            if (monitorHalted) begin // [R14]
               nxt_state = ST_FILL;
            end
         end
         ST_FILL: begin
            if (candAccept) begin
               if (aliasHit) begin
                  // Keep one alias per physical range
                  if (betterAlias(cand, stage_ff[aliasIdx])) begin // [R5]
                     nxt_stage[aliasIdx] = candEntry;
                  end
               end else if (insPos >= segHi) begin
                  nxt_oor = 1'b1; // [R12]
               end else begin
                  // Sorted insert, last entry pushed out
                  if (stage_ff[segHi-4'h1].valid) begin
                     nxt_oor = 1'b1; // [R12]
                  end
                  for (int i = 1; i < NUM_ENTRIES; i++) begin
                     if (4'(i) > insPos && 4'(i) < segHi) begin
                        nxt_stage[i] = stage_ff[i-1]; // [R10] [R11]
                     end
                  end
                  nxt_stage[insPos] = candEntry; // [R9]
               end
            end
            if (loadEnd) begin
               nxt_state = ST_COMMIT;
            end
         end
         ST_COMMIT: begin
            // Freeze the finished table and switch on
            nxt_live = stage_ff; // [R2] [R13]
            nxt_liveSplit = stageSplit_ff;
            nxt_enabled = 1'b1; // [R3]
            nxt_state = ST_IDLE;
         end
      endcase
      // Target held from start until commit
      nxt_halt = (nxt_state != ST_IDLE) && (nxt_state != ST_COMMIT); // [R14]
   end

   // Registers of the sequencer and tables
   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         state_ff <= ST_IDLE;
         stage_ff <= '0;
         live_ff <= '0;
         stageSplit_ff <= 1'b0;
         liveSplit_ff <= 1'b0;
         enabled_ff <= 1'b0;
         oor_ff <= 1'b0;
         halt_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         stage_ff <= nxt_stage;
         live_ff <= nxt_live;
         stageSplit_ff <= nxt_stageSplit;
         liveSplit_ff <= nxt_liveSplit;
         enabled_ff <= nxt_enabled;
         oor_ff <= nxt_oor;
         halt_ff <= nxt_halt;
      end
   end

   assign haltReq = halt_ff;
   assign translating = enabled_ff;
   assign outOfResources = oor_ff;

   // ----------------------------------------------------------------
   // Real-time lookup path
   // ----------------------------------------------------------------
   bus_s ana_ff, nxt_ana; // Address handed to the analyzer
   logic [`RT_IDX_W-1:0] lookLo, lookHi; // Segment searched
   logic hit; // Live entry covers the bus address
   block_t hitLog; // Logical block of the hit

   // Search the live table for the bus address
   always_comb begin
      lookLo = (liveSplit_ff && busIn.isSuper) ? `RT_HALF : 4'h0; // [R19]
      lookHi = liveSplit_ff ? lookLo + `RT_HALF : `RT_FULL;
      hit = 1'b0;
      hitLog = '0;
      for (int i = 0; i < NUM_ENTRIES; i++) begin
         if (4'(i) >= lookLo && 4'(i) < lookHi && live_ff[i].valid &&
               live_ff[i].physBlock == busIn.addr[`RT_ADDR_W-1:`RT_OFS_W]) begin
            hit = 1'b1; // [R20]
            hitLog = live_ff[i].logBlock;
         end
      end
      nxt_ana = busIn; // [R18]
      // Translate only when switched on and the MMU maps
      if (enabled_ff && mmuEnabled && hit) begin // [R1] [R17] [R21]
         nxt_ana.addr = {hitLog, busIn.addr[`RT_OFS_W-1:0]}; // [R20]
      end
   end

   // One pipeline stage, every cycle
   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         ana_ff <= '0;
      end else begin
         ana_ff <= nxt_ana;
      end
   end
   assign anaOut = ana_ff;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_rawDisabled;
      @(posedge sys_clk) disable iff (!rstN)
      (!enabled_ff && mmuEnabled) |=> (anaOut.addr == $past(busIn.addr));
   endproperty
   a_rawDisabled: assert property (p_rawDisabled) else $error("raw address altered"); // [R1]

   property p_mmuOff;
      @(posedge sys_clk) disable iff (!rstN)
      !mmuEnabled |=> (anaOut.addr == $past(busIn.addr));
   endproperty
   a_mmuOff: assert property (p_mmuOff) else $error("translated with mmu off"); // [R17]

   property p_enableAfterLoad;
      @(posedge sys_clk) disable iff (!rstN)
      (state_ff == ST_COMMIT) |=> enabled_ff && (state_ff == ST_IDLE);
   endproperty
   a_enableAfterLoad: assert property (p_enableAfterLoad) else $error("not enabled"); // [R3]

   property p_commitCopies;
      @(posedge sys_clk) disable iff (!rstN)
      (state_ff == ST_COMMIT) |=> (live_ff == $past(stage_ff));
   endproperty
   a_commitCopies: assert property (p_commitCopies) else $error("table not copied"); // [R2]

   property p_liveFrozen;
      @(posedge sys_clk) disable iff (!rstN)
      (state_ff != ST_COMMIT) |=> $stable(live_ff);
   endproperty
   a_liveFrozen: assert property (p_liveFrozen) else $error("live table changed"); // [R13]

   property p_haltDuringFill;
      @(posedge sys_clk) disable iff (!rstN)
      (state_ff == ST_HALT || state_ff == ST_FILL) |-> haltReq;
   endproperty
   a_haltDuringFill: assert property (p_haltDuringFill) else $error("target not halted"); // [R14]

   property p_everyCycle;
      @(posedge sys_clk) disable iff (!rstN)
      busIn.valid |=> anaOut.valid ##0 (anaOut.isSuper == $past(busIn.isSuper));
   endproperty
   a_everyCycle: assert property (p_everyCycle) else $error("bus cycle lost"); // [R18]

   property p_offsetKept;
      @(posedge sys_clk) disable iff (!rstN)
      (enabled_ff && mmuEnabled && hit) |=>
         (anaOut.addr[`RT_OFS_W-1:0] == $past(busIn.addr[`RT_OFS_W-1:0]));
   endproperty
   a_offsetKept: assert property (p_offsetKept) else $error("offset changed"); // [R20]

   property p_missPass;
      @(posedge sys_clk) disable iff (!rstN)
      !hit |=> (anaOut.addr == $past(busIn.addr));
   endproperty
   a_missPass: assert property (p_missPass) else $error("miss altered address"); // [R21]

   property p_overflowFlag;
      @(posedge sys_clk) disable iff (!rstN)
      (candAccept && !aliasHit && insPos >= segHi) |=> outOfResources;
   endproperty
   a_overflowFlag: assert property (p_overflowFlag) else $error("overflow missed"); // [R12]
endmodule

// File: sim/halt_monitor.sv
/*
 * Behavioural target and foreground monitor: breaks into the monitor
 * when the translator asks for a halt, resumes when the request drops.
 * Assumes haltReq is synchronous to sys_clk.
 */
module halt_monitor (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic haltReq,
   input wire logic slow,
   output logic monitorHalted
);
   timeunit 1ns;
   timeprecision 1ps;
   int waitCnt; // Cycles since the request rose
   // Halt after a short or a long break-in, resume at once
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         waitCnt <= 0;
         monitorHalted <= 1'b0;
      end else if (!haltReq) begin // Target runs again
         waitCnt <= 0;
         monitorHalted <= 1'b0;
      end else begin // Break into monitor
         waitCnt <= waitCnt + 1;
         monitorHalted <= (waitCnt >= (slow ? 5 : 1));
      end
   end
endmodule

// File: sim/tb.sv
/*
 * Self-checking bench of the reverse address translator.
 * Assumes the halt_monitor model stands for the target and monitor.
 */
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import rt_pkg::*;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic sys_clk; // 25 MHz
   logic arst_n = 1'b0;
   logic mmuEnabled = 1'b1;
   logic ttFcUsed = 1'b0;
   logic enableCmd = 1'b0;
   logic disableCmd = 1'b0;
   logic loadStart = 1'b0;
   logic fileLoad = 1'b0;
   logic fileSplit = 1'b0;
   logic traceActive = 1'b0;
   logic candValid = 1'b0;
   logic loadEnd = 1'b0;
   logic slow = 1'b0; // Monitor break-in speed
   logic [31:0] user_root_pointer = 32'h0000_1000;
   logic [31:0] supervisor_root_pointer = 32'h0000_1000;
   bus_s busIn = '0;
   cand_s cand = '0;
   logic monitorHalted, candReady, haltReq, translating, outOfResources;
   bus_s anaOut;
   int num_errors = 0;
   int n_tests = 0;
   int cycles = 0;
   cand_s cq[$]; // Candidates of the next load
   // Clock
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   reverse_translator dut (.sys_clk(sys_clk), .arst_n(arst_n), .busIn(busIn),
      .mmuEnabled(mmuEnabled), .user_root_pointer(user_root_pointer),
      .supervisor_root_pointer(supervisor_root_pointer), .ttFcUsed(ttFcUsed),
      .enableCmd(enableCmd), .disableCmd(disableCmd), .loadStart(loadStart),
      .fileLoad(fileLoad), .fileSplit(fileSplit), .traceActive(traceActive),
      .monitorHalted(monitorHalted), .cand(cand), .candValid(candValid),
      .loadEnd(loadEnd), .candReady(candReady), .haltReq(haltReq),
      .translating(translating), .outOfResources(outOfResources), .anaOut(anaOut));
   halt_monitor mon (.sys_clk(sys_clk), .arst_n(arst_n), .haltReq(haltReq),
      .slow(slow), .monitorHalted(monitorHalted));
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic give_verdict();
      if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic check(logic [31:0] seen, logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic tick(int n = 1);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   function automatic cand_s mk(logic s, logic [6:0] p, logic [6:0] l, logic m,
      logic t, logic [31:0] z);
      return '{s, p, l, m, t, z};
   endfunction
   // One bus cycle, answer looked at one cycle later
   task automatic xlate(logic sup, logic [6:0] phys, logic [6:0] exp);
      busIn = '{1'b1, sup, {phys, 25'h1AB_CDEF}};
      tick();
      check(anaOut.addr, {exp, 25'h1AB_CDEF});
      check(anaOut.valid, 1'b1);
      check(anaOut.isSuper, sup);
   endtask
   // Full load of the queued candidates, analyzer kept idle
   task automatic load(logic fl, logic sp);
      int i;
      fileLoad = fl;
      fileSplit = sp;
      loadStart = 1'b1;
      tick();
      loadStart = 1'b0;
      i = 0;
      while (candReady !== 1'b1 && i < 50) begin
         tick();
         i++;
      end
      check(haltReq, 1'b1);
      check(monitorHalted, 1'b1);
      foreach (cq[k]) begin
         cand = cq[k];
         candValid = 1'b1;
         loadEnd = (k == cq.size() - 1);
         tick();
      end
      candValid = 1'b0;
      loadEnd = 1'b0;
      cq.delete();
      tick(2);
      check(haltReq, 1'b0);
      check(candReady, 1'b0);
      check(translating, 1'b1);
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_pass();
      check(translating, 1'b0);
      xlate(1'b0, 7'h05, 7'h05);
   endtask
   task automatic t_alias();
      cq.push_back(mk(1'b0, 7'h01, 7'h05, 1'b0, 1'b0, 32'h0000_0000));
      cq.push_back(mk(1'b0, 7'h01, 7'h03, 1'b0, 1'b0, 32'h0000_0000));
      cq.push_back(mk(1'b0, 7'h02, 7'h01, 1'b0, 1'b1, 32'h0000_0000));
      cq.push_back(mk(1'b0, 7'h02, 7'h09, 1'b0, 1'b0, 32'h0000_0000));
      cq.push_back(mk(1'b0, 7'h03, 7'h02, 1'b0, 1'b0, 32'h0000_0000));
      cq.push_back(mk(1'b0, 7'h03, 7'h08, 1'b1, 1'b0, 32'h0040_0000));
      load(1'b0, 1'b0);
      check(outOfResources, 1'b0);
      xlate(1'b0, 7'h01, 7'h03);
      xlate(1'b1, 7'h02, 7'h09);
      xlate(1'b0, 7'h03, 7'h08);
      xlate(1'b0, 7'h40, 7'h40);
      user_root_pointer = 32'h0000_2000;
      xlate(1'b0, 7'h01, 7'h03);
      user_root_pointer = 32'h0000_1000;
      mmuEnabled = 1'b0;
      xlate(1'b0, 7'h01, 7'h01);
      mmuEnabled = 1'b1;
   endtask
   task automatic t_endis();
      disableCmd = 1'b1;
      tick();
      disableCmd = 1'b0;
      tick();
      check(translating, 1'b0);
      xlate(1'b0, 7'h01, 7'h01);
      enableCmd = 1'b1;
      tick();
      enableCmd = 1'b0;
      tick();
      check(translating, 1'b1);
      xlate(1'b0, 7'h01, 7'h03);
   endtask
   task automatic t_overflow();
      for (int i = 0; i < 8; i++) begin
         cq.push_back(mk(1'b0, 7'h10 + 7'(i), 7'h20 + 7'(i), 1'b0, 1'b0, 32'h0000_0000));
      end
      cq.push_back(mk(1'b0, 7'h30, 7'h50, 1'b1, 1'b0, 32'h0040_0000));
      cq.push_back(mk(1'b0, 7'h31, 7'h51, 1'b1, 1'b0, 32'h0020_0000));
      cq.push_back(mk(1'b0, 7'h40, 7'h60, 1'b0, 1'b0, 32'h0000_0000));
      load(1'b0, 1'b0);
      check(outOfResources, 1'b1);
      xlate(1'b0, 7'h30, 7'h50);
      xlate(1'b0, 7'h31, 7'h51);
      xlate(1'b0, 7'h10, 7'h20);
      xlate(1'b0, 7'h15, 7'h25);
      xlate(1'b0, 7'h16, 7'h16);
      xlate(1'b0, 7'h17, 7'h17);
      xlate(1'b0, 7'h40, 7'h40);
      xlate(1'b0, 7'h01, 7'h01);
   endtask
   task automatic t_file();
      traceActive = 1'b1;
      loadStart = 1'b1;
      tick();
      loadStart = 1'b0;
      tick(3);
      check(haltReq, 1'b0);
      traceActive = 1'b0;
      slow = 1'b1;
      cq.push_back(mk(1'b1, 7'h04, 7'h06, 1'b0, 1'b0, 32'h0000_0000));
      cq.push_back(mk(1'b0, 7'h04, 7'h07, 1'b0, 1'b0, 32'h0000_0000));
      load(1'b1, 1'b1);
      check(outOfResources, 1'b0);
      xlate(1'b1, 7'h04, 7'h06);
      xlate(1'b0, 7'h04, 7'h07);
      xlate(1'b0, 7'h10, 7'h10);
   endtask
   // Split from live pointers or function codes; file load ignores them
   task automatic t_split();
      supervisor_root_pointer = 32'h0000_3000;
      cq.push_back(mk(1'b1, 7'h05, 7'h0A, 1'b0, 1'b0, 32'h0000_0000));
      cq.push_back(mk(1'b0, 7'h05, 7'h0B, 1'b0, 1'b0, 32'h0000_0000));
      load(1'b0, 1'b0);
      xlate(1'b1, 7'h05, 7'h0A);
      xlate(1'b0, 7'h05, 7'h0B);
      cq.push_back(mk(1'b1, 7'h06, 7'h0C, 1'b0, 1'b0, 32'h0000_0000));
      cq.push_back(mk(1'b0, 7'h06, 7'h0D, 1'b0, 1'b0, 32'h0000_0000));
      load(1'b1, 1'b0);
      xlate(1'b0, 7'h06, 7'h0C);
      supervisor_root_pointer = 32'h0000_1000;
      ttFcUsed = 1'b1;
      cq.push_back(mk(1'b1, 7'h05, 7'h0A, 1'b0, 1'b0, 32'h0000_0000));
      cq.push_back(mk(1'b0, 7'h05, 7'h0B, 1'b0, 1'b0, 32'h0000_0000));
      load(1'b0, 1'b0);
      xlate(1'b0, 7'h05, 7'h0B);
      xlate(1'b1, 7'h05, 7'h0A);
      ttFcUsed = 1'b0;
   endtask
   // ------------------------------------------------------------
   // Main sequence and hang guard
   // ------------------------------------------------------------
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         give_verdict();
      end
   end
   initial begin
      repeat (6) @(posedge sys_clk);
      #1;
      arst_n = 1'b1;
      tick(4);
      t_pass();
      t_alias();
      t_endis();
      t_overflow();
      t_file();
      t_split();
      give_verdict();
   end
endmodule
